/* File: inc/dac_ctrl_params.svh */
// Functional notes
// - Two 8-bit code registers, cleared by reset/standby.
// - Enabled channel presents stored code continuously.
// - Control register resets to 0x1F.
// - Bit 7 enables channel 1 conversion and pin.
// - Bit 6 enables channel 0 conversion and pin.
// - Bit 5 joins conversion of both channels.
// - Both enables clear stops all conversion.
// - Pin driven only by its own enable.
// - Joint bit keeps analog bias active.
// - Control bits 4..0 ignore writes, read 1.
// - Code write restarts that channel's conversion.
// - Output appears after conversion delay.
// - Output held until new code or disable.
// - Disabled channel pin is released.
`ifndef DAC_CTRL_PARAMS_SVH
`define DAC_CTRL_PARAMS_SVH

// ****************************************************************
// Register map, indices and byte addresses.
// ****************************************************************
`define DAC_IDX_CODE0 16'hFFF8
`define DAC_IDX_CODE1 16'hFFF9
`define DAC_IDX_CTRL 16'hFFFA
`define DAC_ADDR_CODE0 18'h3FFE0
`define DAC_ADDR_CODE1 18'h3FFE4
`define DAC_ADDR_CTRL 18'h3FFE8
`define DAC_ADDR_W 18

// ****************************************************************
// Fields and reset values.
// ****************************************************************
`define DAC_CODE_RESET 8'h00
`define DAC_CTRL_RESET 8'h1F
`define DAC_CTRL_RSVD 8'h1F
`define DAC_BIT_OE1 7
`define DAC_BIT_OE0 6
`define DAC_BIT_JOINT 5

// ****************************************************************
// Timing: conversion delay in ns and its cycle count at 40 MHz.
// ****************************************************************
`define DAC_CLK_PERIOD_NS 25
`define DAC_CONV_DELAY_NS 10000
`define DAC_CONV_CYCLES ((`DAC_CONV_DELAY_NS + `DAC_CLK_PERIOD_NS - 1) / `DAC_CLK_PERIOD_NS)
`define DAC_CNT_W 9

`endif

/* File: inc/dac_ctrl_pkg.sv */
package dac_ctrl_pkg;

    // Per-channel state of the conversion sequencer.
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_CONV = 2'b01,
        CH_HOLD = 2'b11
    } chan_state_t;

    // Signals to one analog converter cell.
    typedef struct packed {
        logic [7:0] code;
        logic conv_en;
        logic out_en;
        logic valid;
    } dac_cell_t;

endpackage

/* File: hdl/dac_chan_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_params.svh"

module dac_chan_seq (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic standby,
    // Control.
    input wire logic conv_en,
    input wire logic code_write,
    // Status.
    output logic valid
);

    // ****************************************************************
    // Conversion delay sequencer.
    // ****************************************************************
    dac_ctrl_pkg::chan_state_t state_reg;
    logic [`DAC_CNT_W-1:0] cnt_reg;

    // Counts the delay after enable or code write, then holds valid.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= dac_ctrl_pkg::CH_IDLE;
            cnt_reg <= '0;
        end else if (clk_en) begin
            if (standby || !conv_en) begin
                state_reg <= dac_ctrl_pkg::CH_IDLE;
                cnt_reg <= '0;
            end else if (code_write || state_reg == dac_ctrl_pkg::CH_IDLE) begin
                state_reg <= dac_ctrl_pkg::CH_CONV;
                cnt_reg <= `DAC_CNT_W'(`DAC_CONV_CYCLES - 1);
            end else begin
                case (state_reg)
                    dac_ctrl_pkg::CH_CONV: begin
                        if (cnt_reg == '0) begin
                            state_reg <= dac_ctrl_pkg::CH_HOLD;
                        end else begin
                            cnt_reg <= cnt_reg - `DAC_CNT_W'(1);
                        end
                    end
                    dac_ctrl_pkg::CH_HOLD: begin
                        state_reg <= dac_ctrl_pkg::CH_HOLD;
                    end
                    default: begin
                        state_reg <= dac_ctrl_pkg::CH_IDLE;
                    end
                endcase
            end
        end
    end

    // Valid is registered from the next state of the sequencer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valid <= 1'b0;
        end else if (clk_en) begin
            valid <= conv_en && !standby && !code_write
                && state_reg == dac_ctrl_pkg::CH_CONV && cnt_reg == '0;
            if (state_reg == dac_ctrl_pkg::CH_HOLD && conv_en && !standby && !code_write) begin
                valid <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* File: hdl/dac_control_top.sv */
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_params.svh"

module dac_control_top (
    // Clock, reset and freeze.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic standby,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Converter cells.
    output dac_ctrl_pkg::dac_cell_t cell_ch0,
    output dac_ctrl_pkg::dac_cell_t cell_ch1,
    output logic analog_bias_en,
    // Pins: release means the pin floats as an input.
    output logic analog_pin_ch0_oe,
    output logic analog_pin_ch1_oe
);

    // ****************************************************************
    // Address decode.
    // ****************************************************************

    // Maps a byte address to a one-hot select of code0, code1, control.
    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        reg_sel = 3'h0;
        if (a[`DAC_ADDR_W-1:0] == `DAC_ADDR_CODE0 && a[31:`DAC_ADDR_W] == '0) reg_sel = 3'h1;
        if (a[`DAC_ADDR_W-1:0] == `DAC_ADDR_CODE1 && a[31:`DAC_ADDR_W] == '0) reg_sel = 3'h2;
        if (a[`DAC_ADDR_W-1:0] == `DAC_ADDR_CTRL && a[31:`DAC_ADDR_W] == '0) reg_sel = 3'h4;
    endfunction

    logic [2:0] wsel_reg;
    logic [7:0] code0_reg;
    logic [7:0] code1_reg;
    logic [2:0] ctrl_reg;
    logic [2:0] ctrl_next;
    logic oe0;
    logic oe1;
    logic joint;
    logic conv0;
    logic conv1;
    logic wr0;
    logic wr1;
    logic valid0;
    logic valid1;
    logic [2:0] asel;

    assign asel = reg_sel(haddr);

    // Latches a write address phase for the following data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wsel_reg <= 3'h0;
        end else if (clk_en && hready) begin
            wsel_reg <= (hsel && htrans[1] && hwrite) ? asel : 3'h0;
        end
    end

    assign wr0 = clk_en && wsel_reg[0];
    assign wr1 = clk_en && wsel_reg[1];

    // ****************************************************************
    // Registers.
    // ****************************************************************

    // Code registers, cleared by reset and standby.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code0_reg <= `DAC_CODE_RESET;
            code1_reg <= `DAC_CODE_RESET;
        end else if (clk_en) begin
            if (standby) begin
                code0_reg <= `DAC_CODE_RESET;
                code1_reg <= `DAC_CODE_RESET;
            end else begin
                if (wsel_reg[0]) code0_reg <= hwdata[7:0];
                if (wsel_reg[1]) code1_reg <= hwdata[7:0];
            end
        end
    end

    // Only bits 7..5 are stored; low bits are constant ones.
    assign ctrl_next = hwdata[`DAC_BIT_OE1:`DAC_BIT_JOINT];

    // Control register, bits 7..5 reset to zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= 3'(`DAC_CTRL_RESET >> `DAC_BIT_JOINT);
        end else if (clk_en) begin
            if (standby) begin
                ctrl_reg <= 3'(`DAC_CTRL_RESET >> `DAC_BIT_JOINT);
            end else if (wsel_reg[2]) begin
                ctrl_reg <= ctrl_next;
            end
        end
    end

    assign oe1 = ctrl_reg[2];
    assign oe0 = ctrl_reg[1];
    assign joint = ctrl_reg[0];

    // Joint mode converts both when either enable is set.
    assign conv0 = oe0 || (joint && oe1);
    assign conv1 = oe1 || (joint && oe0);

    // ****************************************************************
    // Bus answers.
    // ****************************************************************

    // Read data for the data phase; zero-wait, always OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                case (asel)
                    3'h1: hrdata <= {24'h0, code0_reg};
                    3'h2: hrdata <= {24'h0, code1_reg};
                    3'h4: hrdata <= {24'h0, ctrl_reg, 5'(`DAC_CTRL_RSVD)};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

    // ****************************************************************
    // Channel sequencers.
    // ****************************************************************
    dac_chan_seq seq0 (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .standby(standby),
        .conv_en(conv0),
        .code_write(wr0),
        .valid(valid0)
    );

    dac_chan_seq seq1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .standby(standby),
        .conv_en(conv1),
        .code_write(wr1),
        .valid(valid1)
    );

    // ****************************************************************
    // Converter and pin outputs.
    // ****************************************************************

    // Converter cell signals follow the stored codes and enables.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_ch0 <= '0;
            cell_ch1 <= '0;
        end else if (clk_en) begin
            cell_ch0 <= '{code: code0_reg, conv_en: conv0, out_en: oe0, valid: valid0};
            cell_ch1 <= '{code: code1_reg, conv_en: conv1, out_en: oe1, valid: valid1};
        end
    end

    // Bias stays on in joint mode, even with both pins released.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_bias_en <= 1'b0;
        end else if (clk_en) begin
            analog_bias_en <= joint || oe0 || oe1;
        end
    end

    // Each pin follows its own enable only; joint mode never drives a pin.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_pin_ch0_oe <= 1'b0;
            analog_pin_ch1_oe <= 1'b0;
        end else if (clk_en) begin
            analog_pin_ch0_oe <= oe0;
            analog_pin_ch1_oe <= oe1;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_pin_own_enable: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> analog_pin_ch0_oe == $past(oe0))
        else $error("pin 0 enable does not follow its own bit");

    a_joint_conv: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && joint && oe1 && !oe0) |=> cell_ch0.conv_en)
        else $error("joint mode failed to enable channel 0");

    a_both_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && !oe0 && !oe1) |=> (!cell_ch0.conv_en && !cell_ch1.conv_en))
        else $error("conversion on while both outputs disabled");

    a_bias_joint: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && joint) |=> analog_bias_en)
        else $error("bias off while joint bit set");

    a_rsvd_ones: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && hready && hsel && htrans[1] && !hwrite && asel == 3'h4) |=> hrdata[4:0] == 5'h1F)
        else $error("reserved control bits not read as one");

    a_standby_clr: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && standby) |=> (code0_reg == 8'h00 && code1_reg == 8'h00 && ctrl_reg == 3'h0))
        else $error("standby did not clear registers");

    a_write_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr0 && conv0 && !standby) |=> !valid0)
        else $error("code write did not restart channel 0");

    a_valid_delay: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && !standby && $rose(conv0)) |-> !valid0 [*8])
        else $error("channel 0 valid before conversion delay");

    a_disable_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && !oe0) |=> !analog_pin_ch0_oe)
        else $error("pin 0 still driven after disable");

    a_pin1_enable: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> analog_pin_ch1_oe == $past(oe1))
        else $error("pin 1 enable does not follow its own bit");

    a_out_en_cells: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> (cell_ch1.out_en == $past(oe1) && cell_ch0.out_en == $past(oe0)))
        else $error("cell output enable does not follow its bit");

    a_code_track0: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> cell_ch0.code == $past(code0_reg))
        else $error("channel 0 cell code does not follow its register");

    a_code_track1: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> cell_ch1.code == $past(code1_reg))
        else $error("channel 1 cell code does not follow its register");

    a_freeze_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !clk_en |=> ($stable(cell_ch0) && $stable(cell_ch1) && $stable(analog_bias_en)))
        else $error("cell outputs moved while frozen");

    a_freeze_pins: assert property (@(posedge hclk) disable iff (!hresetn)
        !clk_en |=> ($stable(analog_pin_ch0_oe) && $stable(analog_pin_ch1_oe) && $stable(hrdata)))
        else $error("pin enables or read data moved while frozen");

    a_joint_conv1: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && joint && oe0 && !oe1) |=> cell_ch1.conv_en)
        else $error("joint mode failed to enable channel 1");

    a_split_conv: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && !joint) |=> (cell_ch0.conv_en == $past(oe0) && cell_ch1.conv_en == $past(oe1)))
        else $error("independent mode conversion does not follow own enable");

    a_write_restart1: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr1 && conv1 && !standby) |=> !valid1)
        else $error("code write did not restart channel 1");

    a_valid_delay1: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && !standby && $rose(conv1)) |-> !valid1 [*8])
        else $error("channel 1 valid before conversion delay");

    a_disable_drop1: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && !oe1) |=> !analog_pin_ch1_oe)
        else $error("pin 1 still driven after disable");

    a_valid_needs_conv: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && !conv0) |=> !valid0)
        else $error("channel 0 valid without conversion enabled");

    a_valid_needs_conv1: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && !conv1) |=> !valid1)
        else $error("channel 1 valid without conversion enabled");

    a_hold_valid: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && valid0 && conv0 && !wr0 && !standby) |=> valid0)
        else $error("channel 0 output not held");

    a_hold_valid1: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && valid1 && conv1 && !wr1 && !standby) |=> valid1)
        else $error("channel 1 output not held");

    a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> (hreadyout && !hresp))
        else $error("bus answer not ready and okay");

    a_standby_valid: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && standby) |=> (!valid0 && !valid1))
        else $error("valid still set after standby");

endmodule

`default_nettype wire

/* File: test/dual_channel_dac_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_params.svh"

module dual_channel_dac_control_bench;
    // ****************************************************************
    // Signals, clock and device under test.
    // ****************************************************************
    logic hclk, hresetn, clk_en, standby, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic hreadyout, hresp, bias, pin_oe0, pin_oe1;
    wire logic hready;
    dac_ctrl_pkg::dac_cell_t cell_ch0, cell_ch1;
    int errors, samples_checked, n, i;
    int code_m[2];
    int ctrl_m;

    // The single slave's ready output is the bus ready.
    assign hready = hreadyout;

    // Free-running 40 MHz clock.
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    dac_control_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .standby(standby),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cell_ch0(cell_ch0),
        .cell_ch1(cell_ch1), .analog_bias_en(bias),
        .analog_pin_ch0_oe(pin_oe0), .analog_pin_ch1_oe(pin_oe1)
    );

    // ****************************************************************
    // Reporting and bus tasks.
    // ****************************************************************
    // Ends the run with the verdict.
    task automatic print_verdict;
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Compares one value with the model's expectation.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer; upper write data bits are random noise.
    task automatic bus(input logic wr_en, input logic [17:0] addr, input logic [7:0] wd);
        int k;
        logic [31:0] tmp;
        k = 0;
        tmp = $urandom();
        hsel <= 1'b1;
        haddr <= {14'h0000, addr};
        htrans <= 2'b10;
        hwrite <= wr_en;
        do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {tmp[31:8], wd};
        do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
        if (k >= 100) begin
            errors++;
            $display("ERROR at %0t: bus timeout got %h expected %h", $time, k, 100);
            print_verdict();
        end
    endtask

    // Compares every converter cell field except valid, both pin enables and the bias with the model.
    task automatic check_cells;
        logic o0, o1, j;
        o0 = ctrl_m[6];
        o1 = ctrl_m[7];
        j = ctrl_m[5];
        repeat (3) @(posedge hclk);
        check({24'h000000, cell_ch0.code}, code_m[0]);
        check({24'h000000, cell_ch1.code}, code_m[1]);
        check({31'h0, cell_ch0.conv_en}, {31'h0, o0 | (j & o1)});
        check({31'h0, cell_ch1.conv_en}, {31'h0, o1 | (j & o0)});
        check({30'h0, cell_ch1.out_en, cell_ch0.out_en}, {30'h0, o1, o0});
        check({30'h0, pin_oe1, pin_oe0}, {30'h0, o1, o0});
        check({31'h0, bias}, {31'h0, j | o0 | o1});
    endtask

    // Counts cycles until the chosen channel reports a finished conversion.
    task automatic wait_valid(input int ch);
        n = 0;
        while ((ch ? cell_ch1.valid : cell_ch0.valid) !== 1'b1 && n < 600) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 600) begin
            errors++;
            $display("ERROR at %0t: valid timeout got %h expected %h", $time, n, 600);
            print_verdict();
        end
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        hresetn = 1'b0;
        clk_en = 1'b1;
        standby = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        errors = 0;
        samples_checked = 0;
        code_m = '{0, 0};
        ctrl_m = 32'h1F;
        void'($urandom(32'hD2D74815));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values and an unmapped address.
        bus(1'b0, `DAC_ADDR_CODE0, 8'h00);
        check(rd, 32'h00000000);
        bus(1'b0, `DAC_ADDR_CODE1, 8'h00);
        check(rd, 32'h00000000);
        bus(1'b0, `DAC_ADDR_CTRL, 8'h00);
        check(rd, 32'h0000001F);
        bus(1'b1, 18'h00100, 8'hA5);
        bus(1'b0, 18'h00100, 8'h00);
        check(rd, 32'h00000000);
        check_cells();
        // Code first, then enable channel 0 and time the conversion.
        code_m[0] = $urandom_range(255);
        bus(1'b1, `DAC_ADDR_CODE0, code_m[0][7:0]);
        ctrl_m = 32'h5F;
        bus(1'b1, `DAC_ADDR_CTRL, 8'h40);
        wait_valid(0);
        check(32'(n >= 400 && n <= 406), 32'h1);
        repeat (20) @(posedge hclk);
        check({31'h0, cell_ch0.valid}, 32'h1);
        check_cells();
        // A new code restarts the conversion.
        code_m[0] = code_m[0] ^ 8'hFF;
        bus(1'b1, `DAC_ADDR_CODE0, code_m[0][7:0]);
        repeat (2) @(posedge hclk);
        check({31'h0, cell_ch0.valid}, 32'h0);
        wait_valid(0);
        check(32'(n >= 396 && n <= 406), 32'h1);
        // A low clock enable freezes the outputs and the delay count.
        i = code_m[0];
        code_m[0] = $urandom_range(255);
        bus(1'b1, `DAC_ADDR_CODE0, code_m[0][7:0]);
        clk_en <= 1'b0;
        repeat (410) @(posedge hclk);
        check({24'h000000, cell_ch0.code}, i);
        check({31'h0, cell_ch0.valid}, 32'h1);
        clk_en <= 1'b1;
        repeat (2) @(posedge hclk);
        wait_valid(0);
        check(32'(n >= 396 && n <= 406), 32'h1);
        // Every enable combination, with random codes and noise in the low bits.
        for (i = 0; i < 16; i++) begin
            code_m[i % 2] = $urandom_range(255);
            bus(1'b1, (i % 2) ? `DAC_ADDR_CODE1 : `DAC_ADDR_CODE0, code_m[i % 2][7:0]);
            bus(1'b0, (i % 2) ? `DAC_ADDR_CODE1 : `DAC_ADDR_CODE0, 8'h00);
            check(rd, code_m[i % 2]);
            ctrl_m = ((i % 8) << 5) | 32'h1F;
            bus(1'b1, `DAC_ADDR_CTRL, {i[2:0], 5'($urandom())});
            bus(1'b0, `DAC_ADDR_CTRL, 8'h00);
            check(rd, ctrl_m);
            check_cells();
        end
        // The last channel 1 code write restarted its conversion.
        wait_valid(1);
        check(32'(n >= 390 && n <= 396), 32'h1);
        // Standby clears both codes and the control register.
        bus(1'b1, `DAC_ADDR_CTRL, 8'hE0);
        standby <= 1'b1;
        @(posedge hclk);
        standby <= 1'b0;
        @(posedge hclk);
        code_m = '{0, 0};
        ctrl_m = 32'h1F;
        bus(1'b0, `DAC_ADDR_CODE1, 8'h00);
        check(rd, 32'h00000000);
        bus(1'b0, `DAC_ADDR_CTRL, 8'h00);
        check(rd, 32'h0000001F);
        check_cells();
        print_verdict();
    end
endmodule

`default_nettype wire
